// file: shared/sap_pkg.sv
/*
   Constants, types and helpers for the three-axis servo position loop.
   Assumes a 25 MHz system clock and positions counted in feedback pulses.
*/
package sap_pkg;
   // clock and millisecond timing
   localparam int CLK_NS = 40;
   localparam int MS_NS = 1000000;
   localparam int MS_CYC = MS_NS / CLK_NS;
   // acceleration / deceleration times, milliseconds
   localparam int MS_W = 11;
   localparam logic [MS_W-1:0] ACC_MIN_MS = 11'h004;
   localparam logic [MS_W-1:0] ACC_RAPID_MAX_MS = 11'h200;
   localparam logic [MS_W-1:0] ACC_CUT_MAX_MS = 11'h400;
   localparam logic [MS_W-1:0] ACC_DEF_MS = 11'h064;
   // encoder multiplication factors
   localparam logic [2:0] MF_X1 = 3'h1;
   localparam logic [2:0] MF_X2 = 3'h2;
   localparam logic [2:0] MF_X4 = 3'h4;
   // position gain: setting / 64 is the loop gain
   localparam int GAIN_W = 10;
   localparam logic [GAIN_W-1:0] GAIN_MIN = 10'h008;
   localparam logic [GAIN_W-1:0] GAIN_MAX = 10'h280;
   localparam logic [GAIN_W-1:0] GAIN_FIX = 10'h040;
   localparam logic [GAIN_W-1:0] GAIN_DEF = 10'h040;
   localparam int GAIN_SHIFT = 6;
   localparam logic [15:0] BRK_DEF = 16'h000a;
   // velocity command: 2048 codes at unit gain stand for 10 V
   localparam int VCMD_W = 12;
   localparam logic signed [31:0] FERR_LIM = 32'sh00001000;
   // limits and spans in pulses (0.001 unit per pulse)
   localparam logic signed [31:0] OT_POS_DEF = 32'sh0098967f;
   localparam logic signed [31:0] OT_NEG_DEF = 32'shff676981;
   localparam logic signed [31:0] ROT_SPAN = 32'sh00057e40;
   // program coordinate clear selector bits
   localparam int CLR_END_BIT = 0;
   localparam int CLR_M99_BIT = 1;
   localparam logic ABS_DEF = 1'h1;
   localparam logic ROT_DEF = 1'h0;

   typedef enum logic [1:0] {MV_RAPID, MV_CUT, MV_G99} sap_move_e;
   typedef enum logic {RP_IDLE, RP_RUN} sap_ramp_e;

   function automatic logic [MS_W-1:0] sap_clamp_ms(input logic [MS_W-1:0] v,
                                                     input logic [MS_W-1:0] hi);
      return (v < ACC_MIN_MS) ? ACC_MIN_MS : ((v > hi) ? hi : v);
   endfunction
endpackage

// file: src/sap_servo_axes.sv
/*
   Servo position loop for NAXES axes: quadrature feedback, servo error,
   two-region gain, velocity command, over-travel, homing, coordinate
   clearing and the acceleration ramp timer.
   Assumes encoder pins are asynchronous; all other inputs are on mclk.
*/
`timescale 1ns/100ps
module sap_servo_axes #(
   parameter int NAXES = 3,
   parameter int MS_CYCLES = sap_pkg::MS_CYC
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic enc_a [NAXES],
   input wire logic enc_b [NAXES],
   input wire logic cmd_step [NAXES],
   input wire logic cmd_dir [NAXES],
   input wire logic [2:0] mult_factor [NAXES],
   input wire logic [sap_pkg::GAIN_W-1:0] pos_gain [NAXES],
   input wire logic [15:0] brk_point [NAXES],
   input wire logic signed [31:0] over_travel_limit_pos [NAXES],
   input wire logic signed [31:0] over_travel_limit_neg [NAXES],
   input wire logic signed [31:0] home_shift [NAXES],
   input wire logic [1:0] clr_sel [NAXES],
   input wire logic abs_sel [NAXES],
   input wire logic rot_sel [NAXES],
   input wire logic home_done [NAXES],
   input wire logic end_m02_m30,
   input wire logic end_m99,
   input wire logic err_clear,
   input wire logic profile_sel,
   input wire logic [sap_pkg::MS_W-1:0] acc_rapid_ms,
   input wire logic [sap_pkg::MS_W-1:0] acc_cut_ms,
   input wire logic [sap_pkg::MS_W-1:0] acc_g99_ms,
   input wire logic move_start,
   input wire sap_pkg::sap_move_e move_kind,
   output logic signed [sap_pkg::VCMD_W-1:0] vcmd [NAXES],
   output logic signed [31:0] servo_err [NAXES],
   output logic signed [31:0] mach_pos [NAXES],
   output logic signed [31:0] prog_pos [NAXES],
   output logic follow_err [NAXES],
   output logic ot_pos_hit [NAXES],
   output logic ot_neg_hit [NAXES],
   output logic letter_incr [NAXES],
   output logic aux_valid [NAXES],
   output logic ramp_busy,
   output logic s_curve,
   output logic [sap_pkg::MS_W:0] ramp_ms,
   output logic [sap_pkg::MS_W:0] ramp_elapsed
);
   import sap_pkg::*;

   localparam int TW = $clog2(MS_CYCLES + 1);
   localparam logic signed [42:0] VPOS = 43'((1 << (VCMD_W - 1)) - 1);
   localparam logic signed [42:0] VNEG = -VPOS;

   if (NAXES < 1 || MS_CYCLES < 1) begin : g_bad
      $error("sap_servo_axes: NAXES and MS_CYCLES must be at least 1");
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////////
   // acceleration ramp timer, shared by all axes
   sap_ramp_e rs_q, rs_d;
   logic [TW-1:0] tick_q, tick_d;
   logic [MS_W:0] ms_q, ms_d, dur_q, dur_d;
   logic [MS_W-1:0] base_q, base_d, base;
   logic sc_q, sc_d;
   sap_move_e kind_q, kind_d;

   always_comb begin
      case (move_kind)
         MV_RAPID: base = sap_clamp_ms(acc_rapid_ms, ACC_RAPID_MAX_MS);
         MV_G99: base = sap_clamp_ms(acc_g99_ms, ACC_CUT_MAX_MS);
         default: base = sap_clamp_ms(acc_cut_ms, ACC_CUT_MAX_MS);
      endcase
      rs_d = rs_q;
      tick_d = tick_q;
      ms_d = ms_q;
      dur_d = dur_q;
      base_d = base_q;
      sc_d = sc_q;
      kind_d = kind_q;
      case (rs_q)
         RP_IDLE: begin
            // a start during a running ramp is ignored
            if (move_start) begin
               rs_d = RP_RUN;
               tick_d = '0;
               ms_d = '0;
               base_d = base;
               kind_d = move_kind;
               sc_d = profile_sel;
               dur_d = profile_sel ? {base, 1'b0} : {1'b0, base};
            end
         end
         RP_RUN: begin
            if (tick_q == TW'(MS_CYCLES - 1)) begin
               tick_d = '0;
               ms_d = ms_q + (MS_W+1)'(1);
               if (ms_d == dur_q) begin
                  rs_d = RP_IDLE;
               end
            end else begin
               tick_d = tick_q + TW'(1);
            end
         end
         default: rs_d = RP_IDLE;
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rs_q <= RP_IDLE;
         tick_q <= '0;
         ms_q <= '0;
         dur_q <= '0;
         base_q <= ACC_DEF_MS;
         sc_q <= 1'b0;
         kind_q <= MV_RAPID;
      end else begin
         rs_q <= rs_d;
         tick_q <= tick_d;
         ms_q <= ms_d;
         dur_q <= dur_d;
         base_q <= base_d;
         sc_q <= sc_d;
         kind_q <= kind_d;
      end
   end

   assign ramp_busy = (rs_q == RP_RUN);
   assign s_curve = sc_q;
   assign ramp_ms = dur_q;
   assign ramp_elapsed = ms_q;

   AST_RAMP_DOUBLE: assert property ($rose(ramp_busy) |->
      dur_q == (sc_q ? {base_q, 1'b0} : {1'b0, base_q}))
      else $error("ramp duration does not follow profile");
   AST_RAPID_RANGE: assert property (ramp_busy && kind_q == MV_RAPID |->
      base_q >= ACC_MIN_MS && base_q <= ACC_RAPID_MAX_MS)
      else $error("rapid ramp time out of range");
   AST_CUT_RANGE: assert property (ramp_busy && kind_q != MV_RAPID |->
      base_q >= ACC_MIN_MS && base_q <= ACC_CUT_MAX_MS)
      else $error("cutting ramp time out of range");
   COV_SCURVE: cover property ($rose(ramp_busy) && sc_q);

   ////////////////////////////////////////////////////////////////////////////
   // per-axis loop
   for (genvar i = 0; i < NAXES; i++) begin : g_axis
      logic a1_q, a2_q, ap_q, b1_q, b2_q, bp_q;
      logic signed [31:0] fb_q, fb_d, mach_q, mach_d, prog_q, prog_d, err, aerr;
      logic signed [VCMD_W-1:0] vc_q, vc_d;
      logic signed [42:0] prod, sh;
      logic [GAIN_W-1:0] gain;
      logic ferr_q, ferr_d, ea, eb, up, cnt, stp, ot_p, ot_n;

      always_comb begin
         ea = a2_q ^ ap_q;
         eb = b2_q ^ bp_q;
         up = ~(ap_q ^ b2_q);
         case (mult_factor[i])
            MF_X2: cnt = ea;
            MF_X4: cnt = ea ^ eb;
            default: cnt = ea & a2_q;
         endcase
         // rotary axes turn without end, so no software travel limit
         ot_p = !rot_sel[i] && mach_q >= over_travel_limit_pos[i];
         ot_n = !rot_sel[i] && mach_q <= over_travel_limit_neg[i];
         stp = cmd_step[i] && !(cmd_dir[i] ? ot_n : ot_p);
         err = mach_q - fb_q;
         aerr = (err < 0) ? -err : err;
         if (aerr < $signed({16'h0, brk_point[i]})) begin
            gain = GAIN_FIX;
         end else if (pos_gain[i] < GAIN_MIN) begin
            gain = GAIN_MIN;
         end else if (pos_gain[i] > GAIN_MAX) begin
            gain = GAIN_MAX;
         end else begin
            gain = pos_gain[i];
         end
         prod = 43'(err * $signed({1'b0, gain}));
         sh = prod >>> GAIN_SHIFT;
         if (sh > VPOS) begin
            sh = VPOS;
         end else if (sh < VNEG) begin
            sh = VNEG;
         end
         vc_d = sh[VCMD_W-1:0];
         fb_d = fb_q;
         mach_d = mach_q;
         prog_d = prog_q;
         if (cnt) begin
            fb_d = up ? fb_q + 32'sh1 : fb_q - 32'sh1;
         end
         if (stp) begin
            mach_d = cmd_dir[i] ? mach_q - 32'sh1 : mach_q + 32'sh1;
            prog_d = cmd_dir[i] ? prog_q - 32'sh1 : prog_q + 32'sh1;
         end
         if (rot_sel[i]) begin
            if (prog_d >= ROT_SPAN) begin
               prog_d = prog_d - ROT_SPAN;
            end else if (prog_d < 0) begin
               prog_d = prog_d + ROT_SPAN;
            end
         end
         if ((end_m02_m30 && clr_sel[i][CLR_END_BIT]) ||
             (end_m99 && clr_sel[i][CLR_M99_BIT])) begin
            prog_d = '0;
         end
         if (home_done[i]) begin
            mach_d = home_shift[i];
            prog_d = home_shift[i];
            fb_d = home_shift[i];
         end
         // a new excess wins over a clear in the same cycle
         ferr_d = (aerr > FERR_LIM) || (ferr_q && !err_clear);
      end

      always_ff @(posedge mclk or posedge rst) begin
         if (rst) begin
            {a1_q, a2_q, ap_q, b1_q, b2_q, bp_q} <= '0;
            fb_q <= '0;
            mach_q <= '0;
            prog_q <= '0;
            vc_q <= '0;
            ferr_q <= 1'b0;
         end else begin
            a1_q <= enc_a[i];
            a2_q <= a1_q;
            ap_q <= a2_q;
            b1_q <= enc_b[i];
            b2_q <= b1_q;
            bp_q <= b2_q;
            fb_q <= fb_d;
            mach_q <= mach_d;
            prog_q <= prog_d;
            vc_q <= vc_d;
            ferr_q <= ferr_d;
         end
      end

      assign vcmd[i] = vc_q;
      assign servo_err[i] = err;
      assign mach_pos[i] = mach_q;
      assign prog_pos[i] = prog_q;
      assign follow_err[i] = ferr_q;
      assign ot_pos_hit[i] = ot_p;
      assign ot_neg_hit[i] = ot_n;
      assign letter_incr[i] = ~abs_sel[i];
      assign aux_valid[i] = abs_sel[i];

      AST_X1_RISE: assert property ($changed(fb_q) &&
         $past(mult_factor[i] == MF_X1 && !home_done[i]) |-> $past(a2_q && !ap_q))
         else $error("x1 feedback moved without an A rise");
      AST_FB_STEP: assert property (!$past(home_done[i]) |->
         fb_q == $past(fb_q) || fb_q == $past(fb_q) + 32'sh1 || fb_q == $past(fb_q) - 32'sh1)
         else $error("feedback moved more than one count");
      AST_OT_HOLD: assert property (ot_p && !home_done[i] |=> mach_q <= $past(mach_q))
         else $error("axis moved past positive over-travel");
      AST_OT_NEG: assert property (ot_n && !home_done[i] |=> mach_q >= $past(mach_q))
         else $error("axis moved past negative over-travel");
      AST_HOME: assert property (home_done[i] |=>
         mach_q == $past(home_shift[i]) && prog_q == mach_q && err == 0)
         else $error("homing did not load the shift");
      AST_CLR_M99: assert property (end_m99 && clr_sel[i][CLR_M99_BIT] &&
         !home_done[i] |=> prog_q == 0)
         else $error("program coordinate not cleared on M99");
      AST_LOW_GAIN: assert property (aerr < $signed({16'h0, brk_point[i]}) &&
         aerr <= VPOS |=> vc_q == $past(err[VCMD_W-1:0]))
         else $error("fixed gain of 64 not applied below break-over");
      AST_FERR: assert property (aerr > FERR_LIM |=> ferr_q)
         else $error("following error not raised");
      // the flag stays set until err_clear, even once the error is back in bounds
      AST_FERR_HOLD: assert property (ferr_q && !err_clear |=> ferr_q)
         else $error("following error dropped without a clear");
      COV_FERR: cover property ($rose(ferr_q));
      COV_OT: cover property (ot_p && cmd_step[i] && !cmd_dir[i]);
   end

endmodule // sap_servo_axes

// file: tb/sap_motor_model.sv
/*
   Quadrature encoder of one servo axis, moved one state per request.
   Assumes requests come on mclk, at most one per cycle.
*/
`timescale 1ns/100ps
module sap_motor_model (
   input wire logic mclk,
   input wire logic rst,
   input wire logic step_req,
   input wire logic step_rev,
   output logic enc_a,
   output logic enc_b
);
   logic [1:0] ph_q;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) ph_q <= 2'h0;
      else if (step_req) ph_q <= step_rev ? ph_q - 2'h1 : ph_q + 2'h1;
   end
   // one phase changes per state, a leads b when moving positive
   assign enc_a = (ph_q == 2'h1) || (ph_q == 2'h2);
   assign enc_b = ph_q[1];
endmodule // sap_motor_model

// file: tb/test_servo_axis_position_loop.sv
/*
   Bench for the servo position loop: axis table, then follow error,
   homing, limits, clearing and ramp timing.
   Assumes sap_pkg and sap_servo_axes are compiled first.
*/
`timescale 1ns/100ps
module test_servo_axis_position_loop;
   import sap_pkg::*;
   localparam int NA = 3;
   localparam int MSC = 4;
   typedef struct {int mf; int enc; int cmd; int gain; int err; int vc;} sap_row_s;
   typedef struct {int kind; int prof; int ms; int ex;} sap_ramp_s;
   logic mclk, rst, stp, rev, c_step, c_dir, c_home, ab, rot, e02, e99, eclr, prof, go;
   logic [2:0] mf;
   logic [GAIN_W-1:0] gain;
   logic signed [31:0] otp, otn, hs;
   logic [1:0] clr;
   logic [MS_W-1:0] ms;
   sap_move_e kind;
   logic enc_a [NA], enc_b [NA], cmd_step [NA], cmd_dir [NA], home_done [NA];
   logic [2:0] mult_factor [NA];
   logic [GAIN_W-1:0] pos_gain [NA];
   logic [15:0] brk_point [NA];
   logic signed [31:0] ot_p [NA], ot_n [NA], home_shift [NA];
   logic [1:0] clr_sel [NA];
   logic abs_sel [NA], rot_sel [NA], follow_err [NA], ot_pos_hit [NA], ot_neg_hit [NA];
   logic letter_incr [NA], aux_valid [NA], ramp_busy, s_curve;
   logic signed [VCMD_W-1:0] vcmd [NA];
   logic signed [31:0] servo_err [NA], mach_pos [NA], prog_pos [NA];
   logic [MS_W:0] ramp_ms, ramp_elapsed;
   int failures = 0, comparisons = 0, cyc = 0, n;
   sap_row_s rows [9] = '{'{1, 8, 0, 64, -2, -2}, '{2, 8, 0, 64, -4, -4},
      '{4, 8, 0, 64, -8, -8}, '{3, 8, 0, 64, -2, -2}, '{4, -8, 0, 64, 8, 8},
      '{4, 0, 9, 128, 9, 9}, '{4, 0, 10, 128, 10, 20}, '{4, 0, 20, 1000, 20, 200},
      '{4, 0, 20, 4, 20, 2}};
   sap_ramp_s rr [7] = '{'{0, 0, 100, 100}, '{0, 0, 600, 512}, '{0, 1, 2, 8},
      '{1, 0, 1500, 1024}, '{2, 1, 1024, 2048}, '{1, 0, 3, 4}, '{2, 0, 5, 5}};
   ////////////////////////////////////////////////////////////////////////////////
   for (genvar i = 0; i < NA; i++) begin : g_ax
      assign cmd_step[i] = c_step;
      assign cmd_dir[i] = c_dir;
      assign home_done[i] = c_home;
      assign mult_factor[i] = mf;
      assign pos_gain[i] = gain;
      assign brk_point[i] = BRK_DEF;
      assign ot_p[i] = otp;
      assign ot_n[i] = otn;
      assign home_shift[i] = hs;
      assign clr_sel[i] = clr;
      assign abs_sel[i] = ab;
      assign rot_sel[i] = rot;
      sap_motor_model sap_motor_model_inst (.mclk(mclk), .rst(rst), .step_req(stp),
         .step_rev(rev), .enc_a(enc_a[i]), .enc_b(enc_b[i]));
   end
   sap_servo_axes #(.NAXES(NA), .MS_CYCLES(MSC)) sap_servo_axes_inst (.mclk(mclk),
      .rst(rst), .enc_a(enc_a), .enc_b(enc_b), .cmd_step(cmd_step), .cmd_dir(cmd_dir),
      .mult_factor(mult_factor), .pos_gain(pos_gain), .brk_point(brk_point),
      .over_travel_limit_pos(ot_p), .over_travel_limit_neg(ot_n),
      .home_shift(home_shift), .clr_sel(clr_sel), .abs_sel(abs_sel), .rot_sel(rot_sel),
      .home_done(home_done), .end_m02_m30(e02), .end_m99(e99), .err_clear(eclr),
      .profile_sel(prof), .acc_rapid_ms(ms), .acc_cut_ms(ms), .acc_g99_ms(ms),
      .move_start(go), .move_kind(kind), .vcmd(vcmd), .servo_err(servo_err),
      .mach_pos(mach_pos), .prog_pos(prog_pos), .follow_err(follow_err),
      .ot_pos_hit(ot_pos_hit), .ot_neg_hit(ot_neg_hit), .letter_incr(letter_incr),
      .aux_valid(aux_valid), .ramp_busy(ramp_busy), .s_curve(s_curve),
      .ramp_ms(ramp_ms), .ramp_elapsed(ramp_elapsed));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   task automatic tk(input int k);
      repeat (k) begin
         @(posedge mclk);
         #1;
      end
   endtask
   task automatic chk(input string nm, input logic signed [31:0] seen,
                      input logic signed [31:0] ex);
      comparisons++;
      if (seen !== ex) begin
         failures++;
         $display("BAD %s expected %0d seen %0d", nm, ex, seen);
      end
   endtask
   task automatic summarize();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic cmd(input int k, input logic d);
      c_dir = d;
      repeat (k) begin
         c_step = 1'b1;
         tk(1);
      end
      c_step = 1'b0;
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      tk(1);
      s = 1'b0;
      tk(2);
   endtask
   // whole run is about 20000 cycles
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 40000) begin
         failures++;
         summarize();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {rst, stp, rev, c_step, c_dir, c_home, rot, e02, e99, eclr, prof, go} = 12'h800;
      ab = ABS_DEF;
      mf = MF_X1;
      gain = GAIN_DEF;
      otp = OT_POS_DEF;
      otn = OT_NEG_DEF;
      hs = 32'sh0;
      clr = 2'h0;
      ms = ACC_DEF_MS;
      kind = MV_RAPID;
      tk(5);
      rst = 1'b0;
      tk(1);
      chk("vcmd", vcmd[0], 0);
      chk("follow_err", follow_err[0], 0);
      chk("ramp_busy", ramp_busy, 0);
      chk("ramp_ms", ramp_ms, 0);
      chk("mach_pos", mach_pos[1], 0);
      foreach (rows[r]) begin
         mf = 3'(rows[r].mf);
         gain = GAIN_W'(rows[r].gain);
         pulse(c_home);
         for (int k = 0; k < (rows[r].enc < 0 ? -rows[r].enc : rows[r].enc); k++) begin
            rev = rows[r].enc < 0;
            pulse(stp);
         end
         cmd(rows[r].cmd, 1'b0);
         tk(6);
         for (int a = 0; a < NA; a++) begin
            chk("servo_err", servo_err[a], rows[r].err);
            chk("vcmd", vcmd[a], rows[r].vc);
            chk("mach_pos", mach_pos[a], rows[r].cmd);
         end
      end
      // following error: boundary, sticky while large, then cleared
      gain = GAIN_DEF;
      pulse(c_home);
      cmd(4096, 1'b0);
      tk(3);
      chk("follow_err", follow_err[0], 0);
      cmd(1, 1'b0);
      tk(3);
      chk("follow_err", follow_err[1], 1);
      chk("vcmd", vcmd[0], 2047);
      pulse(eclr);
      chk("follow_err", follow_err[2], 1);
      pulse(c_home);
      pulse(eclr);
      chk("follow_err", follow_err[0], 0);
      hs = 32'sh000004d2;
      pulse(c_home);
      chk("mach_pos", mach_pos[1], 1234);
      chk("prog_pos", prog_pos[1], 1234);
      chk("servo_err", servo_err[1], 0);
      hs = 32'sh0;
      otp = 32'sh5;
      otn = -32'sh3;
      pulse(c_home);
      cmd(8, 1'b0);
      tk(2);
      chk("mach_pos", mach_pos[0], 5);
      chk("ot_pos_hit", ot_pos_hit[0], 1);
      cmd(10, 1'b1);
      tk(2);
      chk("mach_pos", mach_pos[0], -3);
      chk("ot_neg_hit", ot_neg_hit[0], 1);
      rot = 1'b1;
      cmd(5, 1'b1);
      tk(2);
      chk("mach_pos", mach_pos[0], -8);
      chk("ot_neg_hit", ot_neg_hit[0], 0);
      {rot, otp, otn} = {1'b0, OT_POS_DEF, OT_NEG_DEF};
      for (int s = 0; s < 8; s++) begin
         clr = 2'(s / 2);
         ab = 1'(s % 2);
         pulse(c_home);
         cmd(3, 1'b0);
         if (s % 2 == 1) pulse(e99);
         else pulse(e02);
         chk("prog_pos", prog_pos[2], clr[s % 2] ? 0 : 3);
         chk("letter_incr", letter_incr[2], !ab);
         chk("aux_valid", aux_valid[2], ab);
      end
      foreach (rr[r]) begin
         kind = sap_move_e'(rr[r].kind);
         prof = 1'(rr[r].prof);
         ms = MS_W'(rr[r].ms);
         go = 1'b1;
         tk(1);
         chk("ramp_ms", ramp_ms, rr[r].ex);
         chk("s_curve", s_curve, prof);
         ms = 11'h00c;
         n = 0;
         // the second start lands while busy and must be ignored
         while (ramp_busy === 1'b1 && n < 9000) begin
            go = (n == 0);
            n++;
            tk(1);
         end
         go = 1'b0;
         chk("busy_cycles", n, rr[r].ex * MSC);
         chk("ramp_ms", ramp_ms, rr[r].ex);
         chk("ramp_elapsed", ramp_elapsed, rr[r].ex);
      end
      summarize();
   end
endmodule // test_servo_axis_position_loop
